// File: sti_pkg.sv
package sti_pkg;

	// Instruction word width of the core.
	localparam int          INSTR_W           = 10;
	// Opcode of skip_on_conversion_done.
	localparam logic [9:0]  OPC_CONV_DONE     = 10'h287;
	// Opcode of skip_on_ext_input_level.
	localparam logic [9:0]  OPC_EXT_LEVEL     = 10'h03a;

	// Register port geometry.
	localparam int          ADDR_W            = 2;
	localparam int          DATA_W            = 4;
	// Register offsets.
	localparam logic [1:0]  OFS_INT_CTL_ONE   = 2'h0;
	localparam logic [1:0]  OFS_INT_CTL_TWO   = 2'h1;
	localparam logic [1:0]  OFS_STATUS        = 2'h2;

	// Field positions.
	localparam int          BIT_POLARITY_SEL  = 2;
	localparam int          BIT_CONV_IRQ_EN   = 2;
	localparam int          BIT_ST_SKIP       = 0;
	localparam int          BIT_ST_PIN        = 1;
	localparam int          BIT_ST_CONV_FLAG  = 2;

	// Reset values.
	localparam logic [3:0]  RST_INT_CTL       = 4'h0;
	localparam logic [3:0]  RST_RDATA         = 4'h0;

endpackage : sti_pkg

// File: sti_sync2.sv
`timescale 1ns/100ps
module sti_sync2 (
	input  wire logic i_ref_clk,   // Core clock.
	input  wire logic i_resetn,    // Synchronous reset, active low.
	input  wire logic i_async,     // Level from outside the clock domain.
	output logic      o_sync       // Level after two flip-flops.
);
	import sti_pkg::*;

	logic meta_q;                  // First stage, read only by the second stage.
	logic meta_d;                  // Next value of the first stage.
	logic sync_q;                  // Second stage.
	logic sync_d;                  // Next value of the second stage.

	// Next values of the two stages.
	always_comb begin
		meta_d = i_async;
		sync_d = meta_q;
	end

	// Both stages clear under reset so the pin reads low until it settles.
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign o_sync = sync_q;

endmodule : sti_sync2

// File: sti_skip_test.sv
// Contract
// - Opcode 287 selects conversion-done skip test.
// - Enable 0: clear flag, skip if set.
// - Enable 0, flag clear: next executes.
// - Enable 1: instruction acts as no-op.
// - Enable is bit 2, control two.
// - Opcode 03a selects external-level skip test.
// - Polarity 0: skip when pin low.
// - Polarity 1: skip when pin high.
// - Polarity is bit 2, control one.
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/100ps
module sti_skip_test (
	input  wire logic                       i_ref_clk,         // Core clock, 20 MHz.
	input  wire logic                       i_resetn,          // Synchronous reset, active low.
	input  wire logic                       i_instr_valid,     // An instruction executes now.
	input  wire logic [sti_pkg::INSTR_W-1:0] i_instr,          // Instruction word.
	input  wire logic                       i_conv_done_flag,  // Converter completion flag.
	input  wire logic                       i_ext_int_pin,     // External interrupt pin.
	input  wire logic [sti_pkg::ADDR_W-1:0] i_addr,            // Register address.
	input  wire logic [sti_pkg::DATA_W-1:0] i_wdata,           // Register write data.
	input  wire logic                       i_wr,              // Write strobe.
	input  wire logic                       i_rd,              // Read strobe.
	output logic      [sti_pkg::DATA_W-1:0] o_rdata,           // Read data, next cycle.
	output logic                            o_conv_flag_clear, // Clear pulse to converter.
	output logic                            o_exec_inhibit,    // Current instruction nulled.
	output logic                            o_skip_pending     // Next instruction is skipped.
);
	import sti_pkg::*;

	logic        pin_s;            // Synchronised pin level.
	logic [3:0]  ctl_one_q;        // interrupt_control_one.
	logic [3:0]  ctl_one_d;
	logic [3:0]  ctl_two_q;        // interrupt_control_two.
	logic [3:0]  ctl_two_d;
	logic [3:0]  rdata_q;          // Read data register.
	logic [3:0]  rdata_d;
	logic        skip_q;           // Skip pending for next instruction.
	logic        skip_d;
	logic        exec;             // Instruction really executes.
	logic        is_conv;          // Decoded conversion-done skip.
	logic        is_ext;           // Decoded external-level skip.
	logic        conv_en;          // conversion_irq_enable_bit.
	logic        pol_sel;          // input_polarity_select_bit.
	logic        conv_act;         // Conversion test acts this cycle.
	logic        conv_skip;        // Conversion test asks for a skip.
	logic        ext_skip;         // Level test asks for a skip.

	// The pin is asynchronous, so it settles for two cycles before the test sees it.
	sti_sync2 u_pin_sync (
		.i_ref_clk (i_ref_clk),
		.i_resetn  (i_resetn),
		.i_async   (i_ext_int_pin),
		.o_sync    (pin_s)
	);

	// Decode and evaluate both skip tests.
	always_comb begin
		exec      = i_instr_valid && !skip_q;
		is_conv   = (i_instr == OPC_CONV_DONE);
		is_ext    = (i_instr == OPC_EXT_LEVEL);
		conv_en   = ctl_two_q[BIT_CONV_IRQ_EN];
		pol_sel   = ctl_one_q[BIT_POLARITY_SEL];
		// With the enable set the instruction is a plain no-op.
		conv_act  = exec && is_conv && !conv_en;
		conv_skip = conv_act && i_conv_done_flag;
		// Polarity picks which pin level counts as a hit.
		ext_skip  = exec && is_ext && (pol_sel ? pin_s : !pin_s);
	end

	// Flag clear goes out in the executing cycle; the converter lets a new set win.
	assign o_conv_flag_clear = conv_act;
	assign o_exec_inhibit    = i_instr_valid && skip_q;
	assign o_skip_pending    = skip_q;
	assign o_rdata           = rdata_q;

	// Skip state: armed by a hit, consumed by the next instruction.
	always_comb begin
		skip_d = skip_q;
		if (i_instr_valid) begin
			// A nulled instruction can never arm a new skip.
			skip_d = conv_skip || ext_skip;
		end
	end

	// Register port: writes to control, reads registered one cycle later.
	always_comb begin
		ctl_one_d = ctl_one_q;
		ctl_two_d = ctl_two_q;
		rdata_d   = RST_RDATA;
		if (i_wr) begin
			if (i_addr == OFS_INT_CTL_ONE) begin
				ctl_one_d = i_wdata;
			end else if (i_addr == OFS_INT_CTL_TWO) begin
				ctl_two_d = i_wdata;
			end
		end
		if (i_rd) begin
			unique case (i_addr)
				OFS_INT_CTL_ONE: begin
					rdata_d = ctl_one_q;
				end
				OFS_INT_CTL_TWO: begin
					rdata_d = ctl_two_q;
				end
				OFS_STATUS: begin
					rdata_d[BIT_ST_SKIP]      = skip_q;
					rdata_d[BIT_ST_PIN]       = pin_s;
					rdata_d[BIT_ST_CONV_FLAG] = i_conv_done_flag;
				end
				default: begin
					// Unmapped offset reads as zero.
					rdata_d = RST_RDATA;
				end
			endcase
		end
	end

	// State registers.
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			ctl_one_q <= RST_INT_CTL;
			ctl_two_q <= RST_INT_CTL;
			rdata_q   <= RST_RDATA;
			skip_q    <= 1'b0;
		end else begin
			ctl_one_q <= ctl_one_d;
			ctl_two_q <= ctl_two_d;
			rdata_q   <= rdata_d;
			skip_q    <= skip_d;
		end
	end

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_resetn);

	// Skip armed in the cycle after the hit.
	sequence skip_armed_s;
		##1 skip_q;
	endsequence

	// Next instruction nulled and skip consumed.
	sequence next_nulled_s;
		i_instr_valid ##0 o_exec_inhibit ##1 !skip_q;
	endsequence

	conv_skip_a: assert property (exec && i_instr == OPC_CONV_DONE
		&& !ctl_two_q[BIT_CONV_IRQ_EN] && i_conv_done_flag
		|-> skip_armed_s) else $error("conversion skip not armed");
	conv_clear_a: assert property (exec && i_instr == OPC_CONV_DONE
		&& !ctl_two_q[BIT_CONV_IRQ_EN]
		|-> o_conv_flag_clear) else $error("conversion flag not cleared");
	conv_noskip_a: assert property (exec && i_instr == OPC_CONV_DONE && !i_conv_done_flag
		|=> !skip_q) else $error("skip without flag");
	conv_nop_a: assert property (exec && i_instr == OPC_CONV_DONE
		&& ctl_two_q[BIT_CONV_IRQ_EN]
		|-> !o_conv_flag_clear ##1 !skip_q) else $error("no-op form acted");
	ext_low_a: assert property (exec && i_instr == OPC_EXT_LEVEL
		&& !ctl_one_q[BIT_POLARITY_SEL]
		|=> skip_q == !$past(pin_s)) else $error("low-sense skip wrong");
	ext_high_a: assert property (exec && i_instr == OPC_EXT_LEVEL
		&& ctl_one_q[BIT_POLARITY_SEL]
		|=> skip_q == $past(pin_s)) else $error("high-sense skip wrong");
	null_next_a: assert property (skip_q && i_instr_valid
		|-> !o_conv_flag_clear ##0 next_nulled_s) else $error("skipped word acted");
	clear_src_a: assert property (o_conv_flag_clear
		|-> i_instr == OPC_CONV_DONE && i_instr_valid && !skip_q) else $error("stray clear");
	skip_src_a: assert property ($rose(skip_q)
		|-> $past(i_instr) == OPC_CONV_DONE || $past(i_instr) == OPC_EXT_LEVEL)
		else $error("stray skip");
	pin_lat_a: assert property (exec && i_instr == OPC_EXT_LEVEL
		&& !ctl_one_q[BIT_POLARITY_SEL] && $past(i_ext_int_pin, 2)
		&& $past(i_resetn, 2) && $past(i_resetn) |=> !skip_q)
		else $error("pin sync path wrong");

	// A level test must never touch the converter flag.
	// Only the conversion test may drive the clear line.
	ext_noclear_a: assert property (exec && i_instr == OPC_EXT_LEVEL
		|-> !o_conv_flag_clear)
		else $error("level test cleared flag");

	// A pending skip survives idle cycles until a word consumes it.
	// Without this a stall between fetches would lose the skip.
	skip_hold_a: assert property (skip_q && !i_instr_valid
		|=> skip_q)
		else $error("skip lost while idle");

	// The polarity bit must come from what software wrote.
	// A write lands in the cycle after its strobe.
	wr_one_a: assert property (i_wr && i_addr == OFS_INT_CTL_ONE
		|=> ctl_one_q == $past(i_wdata))
		else $error("control one write lost");

	// The enable bit must come from what software wrote.
	// The same one-cycle landing applies here.
	wr_two_a: assert property (i_wr && i_addr == OFS_INT_CTL_TWO
		|=> ctl_two_q == $past(i_wdata))
		else $error("control two write lost");

	// Read data of control one stands in the cycle after the strobe.
	// Software polls this to check the polarity it set.
	rd_one_a: assert property (i_rd && i_addr == OFS_INT_CTL_ONE
		|=> o_rdata == $past(ctl_one_q))
		else $error("control one read wrong");

	// Read data of control two stands in the cycle after the strobe.
	rd_two_a: assert property (i_rd && i_addr == OFS_INT_CTL_TWO
		|=> o_rdata == $past(ctl_two_q))
		else $error("control two read wrong");

	// Read data falls back to zero when no read was asked for.
	// This keeps a stale value from looking like a fresh answer.
	rd_idle_a: assert property (!i_rd
		|=> o_rdata == RST_RDATA)
		else $error("read data outlived its cycle");

	// Writes to the status offset are ignored; controls keep their value.
	st_ro_a: assert property (i_wr && i_addr == OFS_STATUS
		|=> ctl_one_q == $past(ctl_one_q) && ctl_two_q == $past(ctl_two_q))
		else $error("status write changed controls");

endmodule : sti_skip_test

// File: sti_far_model.sv
`timescale 1ns/100ps
// Converter completion flag and external pin as seen by the skip logic.
module sti_far_model (
	input  wire logic i_ref_clk, // Core clock.
	input  wire logic i_resetn,  // Synchronous reset, active low.
	input  wire logic i_set,     // Conversion finished this cycle.
	input  wire logic i_clear,   // Clear pulse from the skip logic.
	input  wire logic i_level,   // Level to put on the pin.
	output logic      o_flag,    // Completion flag.
	output logic      o_pin      // External interrupt pin.
);
	// A set in the same cycle as a clear wins, so no completion is lost.
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) o_flag <= 1'b0;
		else if (i_set) o_flag <= 1'b1;
		else if (i_clear) o_flag <= 1'b0;
	end
	// The pin is always driven, so it never floats.
	assign o_pin = i_level;
endmodule : sti_far_model

// File: testbench.sv
`timescale 1ns/100ps
module testbench;
	import sti_pkg::*;
	logic clk, rstn, vld, wr, rd, set, lvl, clr, inh, skp, flag, pin;
	logic [INSTR_W-1:0] ins;
	logic [ADDR_W-1:0]  adr;
	logic [DATA_W-1:0]  wd, rdat;
	int                 n_fail, check_count;
	sti_skip_test sti_skip_test_inst (.i_ref_clk(clk), .i_resetn(rstn), .i_instr_valid(vld),
		.i_instr(ins), .i_conv_done_flag(flag), .i_ext_int_pin(pin), .i_addr(adr),
		.i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .o_conv_flag_clear(clr),
		.o_exec_inhibit(inh), .o_skip_pending(skp));
	sti_far_model sti_far_model_inst (.i_ref_clk(clk), .i_resetn(rstn), .i_set(set),
		.i_clear(clr), .i_level(lvl), .o_flag(flag), .o_pin(pin));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Case equality keeps an unknown from passing as a match.
	task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wrr(input logic [1:0] a, input logic [3:0] d);
		@(posedge clk) begin wr <= 1'b1; adr <= a; wd <= d; end
		@(posedge clk) wr <= 1'b0;
	endtask : wrr
	task automatic rdr(input logic [1:0] a, input logic [3:0] e);
		@(posedge clk) begin rd <= 1'b1; adr <= a; end
		@(posedge clk) rd <= 1'b0;
		#1 chk("rdata", e, rdat);
	endtask : rdr
	// One instruction; clear and inhibit are combinational, skip is seen next cycle.
	task automatic ex(input logic [9:0] i, input logic ec, ei, es);
		@(posedge clk) begin vld <= 1'b1; ins <= i; end
		#1 chk("clear", {3'h0, ec}, {3'h0, clr});
		chk("inhibit", {3'h0, ei}, {3'h0, inh});
		@(posedge clk) vld <= 1'b0;
		#1 chk("skip", {3'h0, es}, {3'h0, skp});
	endtask : ex
	task automatic pulse_set();
		@(posedge clk) set <= 1'b1;
		@(posedge clk) set <= 1'b0;
	endtask : pulse_set
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : report_and_stop
	initial begin
		{rstn, vld, wr, rd, set, lvl, ins, adr, wd} = '0;
		n_fail = 0;
		check_count = 0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		rdr(OFS_INT_CTL_ONE, 4'h0);
		rdr(OFS_INT_CTL_TWO, 4'h0);
		wrr(OFS_INT_CTL_ONE, 4'h4);
		wrr(OFS_INT_CTL_TWO, 4'h4);
		rdr(OFS_INT_CTL_ONE, 4'h4);
		rdr(OFS_INT_CTL_TWO, 4'h4);
		rdr(2'h3, 4'h0);
		wrr(OFS_STATUS, 4'hf);
		rdr(OFS_STATUS, 4'h0);
		@(posedge clk) #1 chk("rdata idle", 4'h0, rdat);
		$display("registers done");
		// Enable bit set: the test is a no-op and the flag survives.
		pulse_set();
		rdr(OFS_STATUS, 4'h4);
		ex(OPC_CONV_DONE, 1'b0, 1'b0, 1'b0);
		chk("flag", 4'h1, {3'h0, flag});
		wrr(OFS_INT_CTL_TWO, 4'h0);
		ex(OPC_CONV_DONE, 1'b1, 1'b0, 1'b1);
		// A nulled test word must neither clear nor arm a new skip.
		ex(OPC_CONV_DONE, 1'b0, 1'b1, 1'b0);
		chk("flag", 4'h0, {3'h0, flag});
		ex(OPC_CONV_DONE, 1'b1, 1'b0, 1'b0);
		$display("conversion test done");
		for (int p = 0; p < 2; p++) begin
			for (int l = 0; l < 2; l++) begin
				wrr(OFS_INT_CTL_ONE, p[0] ? 4'h4 : 4'h0);
				@(posedge clk) lvl <= l[0];
				repeat (3) @(posedge clk);
				rdr(OFS_STATUS, l[0] ? 4'h2 : 4'h0);
				ex(OPC_EXT_LEVEL, 1'b0, 1'b0, p == l);
				if (p == l) ex(10'h000, 1'b0, 1'b1, 1'b0);
			end
		end
		$display("pin test done");
		// A mid-run reset must bring both controls back to zero.
		@(posedge clk) rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rdr(OFS_INT_CTL_ONE, 4'h0);
		rdr(OFS_INT_CTL_TWO, 4'h0);
		$display("reset test done");
		report_and_stop();
	end
endmodule : testbench
